// ==== verilog/kps_map.svh ====
// Keypad scanner constants: register indices, reset values, field positions, timing.
// Assumes inclusion by bare name from the keypad scanner design files.
`ifndef KPS_MAP_SVH
`define KPS_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define KPS_IDX_COL 10'h0D1
`define KPS_IDX_ROW 10'h0D2
`define KPS_IDX_TIM 10'h0D3
`define KPS_IDX_CTRL 10'h0D4

// Reset values
`define KPS_RST_COL 8'h1F
`define KPS_RST_ROW 8'h3F
`define KPS_RST_TIM 8'h00
`define KPS_RST_CTRL 8'h00

// Control/status bit positions
`define KPS_BIT_IRQ_EN 0
`define KPS_BIT_FLAG 1
`define KPS_BIT_AUTO 2
`define KPS_BIT_CLKLVL 3

// Timing: one keypad clock period and the system clock period, in ns
`define KPS_MS_NS 1000000
`define KPS_CLK_NS 5
`define KPS_MS_CYC (`KPS_MS_NS / `KPS_CLK_NS)

// Debounce step and the zero-field case, in ms
`define KPS_DB_STEP_MS 9'h004
`define KPS_DB_ZERO_MS 9'h100

// Scan interval per code, in ms
`define KPS_SC_MS_00 9'h004
`define KPS_SC_MS_01 9'h001
`define KPS_SC_MS_10 9'h002
`define KPS_SC_MS_11 9'h003

// Bus responses
`define KPS_RESP_OKAY 2'h0
`define KPS_RESP_DECERR 2'h3

`endif

// ==== verilog/kps_pkg.sv ====
// Keypad scanner types: scan states and register selection.
// Assumes nothing beyond a SystemVerilog compiler.
package kps_pkg;

	typedef enum logic [2:0] {
		KPS_ST_IDLE,
		KPS_ST_DB_PRESS,
		KPS_ST_SCAN,
		KPS_ST_WAIT_REL,
		KPS_ST_DB_REL
	} kps_state_t;

	typedef enum logic [2:0] {
		KPS_SEL_NONE,
		KPS_SEL_COL,
		KPS_SEL_ROW,
		KPS_SEL_TIM,
		KPS_SEL_CTRL
	} kps_sel_t;

endpackage

// ==== verilog/kps_tmr_if.sv ====
// Interface between the keypad scan control and its millisecond timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface kps_tmr_if;
	logic load;
	logic [8:0] value;
	logic done;
	logic level;

	modport ctrl (output load, output value, input done, input level);
	modport tmr (input load, input value, output done, output level);
endinterface

// ==== verilog/kps_timer.sv ====
// Keypad 1 kHz time base and millisecond down-counter.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/1ps
`include "kps_map.svh"

module kps_timer #(
	parameter int unsigned MS_CYC = `KPS_MS_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	kps_tmr_if.tmr tmr
);
	localparam int CW = $clog2(MS_CYC);

	logic [CW-1:0] cyc_q;
	logic lvl_q;
	logic [8:0] cnt_q;
	logic ms_tick;
	logic half_tick;

	// Free-running time base: the first tick of a wait can fall less than one keypad clock period after the load
	assign ms_tick = (cyc_q == CW'(MS_CYC - 1));
	assign half_tick = (cyc_q == CW'(MS_CYC / 2 - 1));
	assign tmr.done = (cnt_q == 9'h000);
	assign tmr.level = lvl_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cyc_q <= '0;
			lvl_q <= 1'b0;
		end else begin
			cyc_q <= ms_tick ? '0 : cyc_q + CW'(1);
			if (ms_tick || half_tick) begin
				lvl_q <= !lvl_q;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 9'h000;
		end else if (tmr.load) begin
			cnt_q <= tmr.value;
		end else if (ms_tick && cnt_q != 9'h000) begin
			cnt_q <= cnt_q - 9'h001;
		end
	end

	tick_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		ms_tick |=> !ms_tick)
		else $error("keypad tick lasted more than one cycle");

endmodule // kps_timer

// ==== verilog/kps_top.sv ====
// Keypad matrix scanner with AXI4-Lite register access.
// Assumes row inputs synchronous to i_clk with pull-ups; columns drive the matrix.
// Behaviour
// - A validated key's column pattern is stored in the column register.
// - In bypass mode, column register bits 4..0 drive column outputs 4..0 one to one.
// - Columns are active low: 0x1E pulls column zero, 0x1F releases all.
// - In bypass mode the written column value appears on the column outputs.
// - Column register resets to 0x1F, all columns high.
// - A validated key's row pattern is stored in the six-bit row register.
// - Rows read active low; row register resets to 0x3F.
// - Timing register: debounce field bits 7..2, scan interval bits 1..0.
// - Debounce is field times 4 ms; zero means 256 ms.
// - Both presses and releases are debounced by that period.
// - Scan interval code 01 waits 1 ms, code 10 waits 2 ms.
// - One control/status register, reset zero, holds scan, detect and interrupt bits.
// - Auto-scan enable set scans in hardware; clear means bypass mode.
// - Key-detect flag set on valid key or bypass row fall; read clears it.
// - Interrupt enable gates only the interrupt, never the flag itself.
// - Control/status bit 3 reads the keypad clock level.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "kps_map.svh"

module kps_top
	import kps_pkg::*;
#(
	parameter int unsigned MS_CYC = `KPS_MS_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	input wire logic [11:0] i_awaddr,
	input wire logic i_wvalid,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic [11:0] i_araddr,
	input wire logic i_rready,
	input wire logic [5:0] i_row,
	output logic o_awready,
	output logic o_wready,
	output logic o_bvalid,
	output logic [1:0] o_bresp,
	output logic o_arready,
	output logic o_rvalid,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic [4:0] o_col,
	output logic o_irq
);

	function automatic kps_sel_t kps_dec(input logic [11:0] addr);
		kps_sel_t sel;
		sel = KPS_SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			case (addr[11:2])
				`KPS_IDX_COL: sel = KPS_SEL_COL;
				`KPS_IDX_ROW: sel = KPS_SEL_ROW;
				`KPS_IDX_TIM: sel = KPS_SEL_TIM;
				`KPS_IDX_CTRL: sel = KPS_SEL_CTRL;
				default: sel = KPS_SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	function automatic logic [2:0] kps_ones(input logic [5:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int k = 0; k < 6; k++) begin
			n = n + 3'(v[k]);
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync_q;
	logic rst_n_s;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_s = rst_sync_q[1];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n_s);

	////////////////////////////////////////////////////////////////////////////
	// Registers and timer
	logic [7:0] col_q;
	logic [7:0] row_q;
	logic [7:0] tim_q;
	logic auto_q;
	logic irq_en_q;
	logic flag_q;
	logic flag_d;
	logic rows_hi_q;

	kps_tmr_if u_tmr_if ();

	kps_timer #(.MS_CYC(MS_CYC)) u_timer (
		.i_clk(i_clk),
		.i_rst_n(rst_n_s),
		.tmr(u_tmr_if.tmr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Scan engine
	kps_state_t state_q;
	kps_state_t state_d;
	logic [2:0] col_idx_q;
	logic [1:0] hits_q;
	logic [1:0] hits_new;
	logic [4:0] hit_col_q;
	logic [5:0] hit_row_q;
	logic [4:0] scan_drive;
	logic [2:0] n_low;
	logic any_low;
	logic all_high;
	logic step_done;
	logic last_col;
	logic cap_fire;
	logic [4:0] cap_col;
	logic [5:0] cap_row;
	logic [8:0] db_ms;
	logic [8:0] sc_ms;
	logic tmr_load;
	logic [8:0] tmr_value;

	assign all_high = &i_row;
	assign any_low = !all_high;
	assign n_low = kps_ones(~i_row);
	assign last_col = (col_idx_q == 3'h4);
	assign step_done = (state_q == KPS_ST_SCAN) && u_tmr_if.done;
	// Two or more closures anywhere in the matrix make the scan invalid
	assign hits_new = (hits_q == 2'h2 || n_low > 3'h1 || (hits_q == 2'h1 && n_low != 3'h0)) ?
		2'h2 : (hits_q | n_low[1:0]);
	assign cap_fire = step_done && last_col && hits_new == 2'h1;
	assign cap_col = (hits_q == 2'h0) ? scan_drive : hit_col_q;
	assign cap_row = (hits_q == 2'h0) ? i_row : hit_row_q;
	assign db_ms = (tim_q[7:2] == 6'h00) ? `KPS_DB_ZERO_MS : 9'(tim_q[7:2]) * `KPS_DB_STEP_MS;
	assign sc_ms = (tim_q[1:0] == 2'h1) ? `KPS_SC_MS_01 :
		(tim_q[1:0] == 2'h2) ? `KPS_SC_MS_10 :
		(tim_q[1:0] == 2'h3) ? `KPS_SC_MS_11 : `KPS_SC_MS_00;
	assign u_tmr_if.load = tmr_load;
	assign u_tmr_if.value = tmr_value;

	// Outside a scan step every column is pulled low to catch any closure
	for (genvar g = 0; g < 5; g++) begin : g_drive
		assign scan_drive[g] = (state_q == KPS_ST_SCAN) && (col_idx_q != 3'(g));
	end

	always_comb begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_value = db_ms;
		case (state_q)
			KPS_ST_IDLE: begin
				if (any_low) begin
					state_d = KPS_ST_DB_PRESS;
					tmr_load = 1'b1;
				end
			end
			KPS_ST_DB_PRESS: begin
				if (u_tmr_if.done) begin
					state_d = any_low ? KPS_ST_SCAN : KPS_ST_IDLE;
					tmr_load = any_low;
					tmr_value = sc_ms;
				end
			end
			KPS_ST_SCAN: begin
				if (u_tmr_if.done) begin
					state_d = last_col ? KPS_ST_WAIT_REL : KPS_ST_SCAN;
					tmr_load = !last_col;
					tmr_value = sc_ms;
				end
			end
			KPS_ST_WAIT_REL: begin
				if (all_high) begin
					state_d = KPS_ST_DB_REL;
					tmr_load = 1'b1;
				end
			end
			KPS_ST_DB_REL: begin
				if (u_tmr_if.done) begin
					state_d = all_high ? KPS_ST_IDLE : KPS_ST_WAIT_REL;
				end
			end
			default: state_d = KPS_ST_IDLE;
		endcase
		if (!auto_q) begin
			state_d = KPS_ST_IDLE;
			tmr_load = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_q <= KPS_ST_IDLE;
			col_idx_q <= 3'h0;
			hits_q <= 2'h0;
			hit_col_q <= 5'h1F;
			hit_row_q <= 6'h3F;
		end else begin
			state_q <= state_d;
			if (state_q != KPS_ST_SCAN) begin
				col_idx_q <= 3'h0;
				hits_q <= 2'h0;
			end else if (step_done) begin
				col_idx_q <= col_idx_q + 3'h1;
				hits_q <= hits_new;
				if (hits_q == 2'h0 && n_low == 3'h1) begin
					hit_col_q <= scan_drive;
					hit_row_q <= i_row;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic aw_got_q;
	logic w_got_q;
	logic [11:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic wstrb0_q;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic wr_fire;
	kps_sel_t wr_sel;
	kps_sel_t rd_sel;
	logic [7:0] ctrl_rd;
	logic [7:0] rd_byte;
	logic rd_clear;
	logic wr_clear;
	logic set_ev;

	assign aw_hs = i_awvalid && o_awready;
	assign w_hs = i_wvalid && o_wready;
	assign ar_hs = i_arvalid && o_arready;
	assign wr_fire = aw_got_q && w_got_q && !o_bvalid;
	assign wr_sel = kps_dec(awaddr_q);
	assign rd_sel = kps_dec(i_araddr);
	assign ctrl_rd = (8'(u_tmr_if.level) << `KPS_BIT_CLKLVL) | (8'(auto_q) << `KPS_BIT_AUTO) |
		(8'(flag_q) << `KPS_BIT_FLAG) | (8'(irq_en_q) << `KPS_BIT_IRQ_EN);
	assign rd_byte = (rd_sel == KPS_SEL_COL) ? col_q :
		(rd_sel == KPS_SEL_ROW) ? row_q :
		(rd_sel == KPS_SEL_TIM) ? tim_q :
		(rd_sel == KPS_SEL_CTRL) ? ctrl_rd : 8'h00;

	always_ff @(posedge i_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= `KPS_RESP_OKAY;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 12'h000;
			wbyte_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			if (aw_hs) begin
				aw_got_q <= 1'b1;
				awaddr_q <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (w_hs) begin
				w_got_q <= 1'b1;
				wbyte_q <= i_wdata[7:0];
				wstrb0_q <= i_wstrb[0];
				o_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (wr_sel == KPS_SEL_NONE) ? `KPS_RESP_DECERR : `KPS_RESP_OKAY;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `KPS_RESP_OKAY;
		end else if (ar_hs) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= {24'h00_0000, rd_byte};
			o_rresp <= (rd_sel == KPS_SEL_NONE) ? `KPS_RESP_DECERR : `KPS_RESP_OKAY;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file, flag and outputs
	logic wr_ok;
	assign wr_ok = wr_fire && wstrb0_q;
	assign rd_clear = ar_hs && rd_sel == KPS_SEL_CTRL;
	assign wr_clear = wr_ok && wr_sel == KPS_SEL_CTRL && wbyte_q[`KPS_BIT_FLAG];
	// Bypass edge detect rides on raw rows, so a bouncing key may raise it again
	assign set_ev = auto_q ? cap_fire : (rows_hi_q && !all_high);
	assign flag_d = set_ev || (flag_q && !(rd_clear || wr_clear));

	always_ff @(posedge i_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			col_q <= `KPS_RST_COL;
			row_q <= `KPS_RST_ROW;
			tim_q <= `KPS_RST_TIM;
			auto_q <= 1'(`KPS_RST_CTRL >> `KPS_BIT_AUTO);
			irq_en_q <= 1'(`KPS_RST_CTRL >> `KPS_BIT_IRQ_EN);
			flag_q <= 1'(`KPS_RST_CTRL >> `KPS_BIT_FLAG);
			rows_hi_q <= 1'b1;
			o_col <= 5'h1F;
			o_irq <= 1'b0;
		end else begin
			rows_hi_q <= all_high;
			flag_q <= flag_d;
			if (cap_fire) begin
				col_q <= {3'h0, cap_col};
				row_q <= {2'h0, cap_row};
			end else begin
				if (wr_ok && wr_sel == KPS_SEL_COL) begin
					col_q <= {3'h0, wbyte_q[4:0]};
				end
				if (!auto_q) begin
					row_q <= {2'h0, i_row};
				end
			end
			if (wr_ok && wr_sel == KPS_SEL_TIM) begin
				tim_q <= wbyte_q;
			end
			if (wr_ok && wr_sel == KPS_SEL_CTRL) begin
				auto_q <= wbyte_q[`KPS_BIT_AUTO];
				irq_en_q <= wbyte_q[`KPS_BIT_IRQ_EN];
			end
			o_col <= auto_q ? scan_drive : col_q[4:0];
			o_irq <= flag_q && irq_en_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_press_ok;
		state_q == KPS_ST_DB_PRESS && u_tmr_if.done && any_low && auto_q;
	endsequence
	sequence s_release_ok;
		state_q == KPS_ST_DB_REL && u_tmr_if.done && all_high && auto_q;
	endsequence

	bypass_drive_a: assert property (!auto_q ##1 !auto_q |-> o_col == $past(col_q[4:0]))
		else $error("bypass column output differs from column register");
	capture_col_a: assert property (cap_fire && auto_q |=> col_q[4:0] == $past(cap_col) && flag_q)
		else $error("valid key column not captured");
	capture_row_a: assert property (cap_fire && auto_q |=> row_q[5:0] == $past(cap_row))
		else $error("valid key row not captured");
	scan_onehot_a: assert property (state_q == KPS_ST_SCAN && auto_q |=> $countones(~o_col) == 1)
		else $error("scan step drives other than one column low");
	debounce_load_a: assert property (state_q == KPS_ST_IDLE && tmr_load |->
		tmr_value == ((tim_q[7:2] == 6'h00) ? 9'h100 : {1'b0, tim_q[7:2], 2'h0}))
		else $error("debounce period wrong");
	scan_load_a: assert property (state_q == KPS_ST_SCAN && tmr_load |->
		tmr_value == ((tim_q[1:0] == 2'h0) ? 9'h004 : {7'h00, tim_q[1:0]}))
		else $error("scan interval wrong");
	press_step_a: assert property (s_press_ok |=> state_q == KPS_ST_SCAN && col_idx_q == 3'h0)
		else $error("debounced press did not start a scan");
	release_step_a: assert property (s_release_ok |=> state_q == KPS_ST_IDLE ##1 o_col == 5'h00)
		else $error("debounced release did not return to idle");
	irq_gate_a: assert property (flag_q && !irq_en_q |=> !o_irq)
		else $error("masked flag raised interrupt");
	read_clear_a: assert property (rd_clear && !set_ev |=> !flag_q ##1 o_irq == 1'b0)
		else $error("read did not clear key detect flag");

endmodule // kps_top

// ==== dv/kps_keypad_model.sv ====
// Keypad switch matrix model: at most one key closed, at a chosen crossing.
// Assumes rows carry pull-ups, so an open row reads high.
`timescale 1ns/1ps

module kps_keypad_model (
	input wire logic [4:0] i_col,
	input wire logic i_press,
	input wire logic [2:0] i_key_col,
	input wire logic [2:0] i_key_row,
	output logic [5:0] o_row
);
	// A closed switch pulls its row low only while its column is driven low
	always_comb begin
		o_row = 6'h3F;
		if (i_press && !i_col[i_key_col])
			o_row[i_key_row] = 1'b0;
	end
endmodule // kps_keypad_model

// ==== dv/keypad_scan_registers_bench.sv ====
// Self-checking bench for the keypad scanner: register bus, bypass mode and hardware scan.
// Assumes the design files compile first and the matrix model drives the rows.
`timescale 1ns/1ps
`include "kps_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module keypad_scan_registers_bench;
	localparam int MS = 20;
	localparam logic [11:0] A_COL = {`KPS_IDX_COL, 2'b00};
	localparam logic [11:0] A_ROW = {`KPS_IDX_ROW, 2'b00};
	localparam logic [11:0] A_TIM = {`KPS_IDX_TIM, 2'b00};
	localparam logic [11:0] A_CTRL = {`KPS_IDX_CTRL, 2'b00};
	localparam logic [1:0] OK = `KPS_RESP_OKAY;
	localparam logic [1:0] DEC = `KPS_RESP_DECERR;
	typedef struct {logic [33:0] v; logic [33:0] m;} kps_note_t;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, press;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, last_rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, seen;
	logic [5:0] row;
	logic [4:0] col;
	logic [2:0] kc, kr;
	logic [7:0] rnd, v;
	logic [7:0] tv [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h01};
	int dbv [5] = '{4, 4, 4, 4, 256};
	int scv [5] = '{4, 1, 2, 3, 1};
	kps_note_t notes[$];
	kps_note_t cur;
	logic [33:0] got;
	int failures, check_count, n, t;

	kps_top #(.MS_CYC(MS)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(wstrb), .i_bready(bready), .i_arvalid(arvalid),
		.i_araddr(araddr), .i_rready(rready), .i_row(row), .o_awready(awready), .o_wready(wready),
		.o_bvalid(bvalid), .o_bresp(bresp), .o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata),
		.o_rresp(rresp), .o_col(col), .o_irq(irq));

	kps_keypad_model keypad (.i_col(col), .i_press(press), .i_key_col(kc), .i_key_row(kr), .o_row(row));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks note the expected answer, the monitor compares it at the handshake

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
		logic ad;
		logic wd;
		notes.push_back('{{r, 32'h0}, {2'h3, 32'h0}});
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {rnd, rnd, rnd, d};
		wstrb <= s;
		bready <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m, input logic [1:0] r);
		notes.push_back('{{r, 24'h0, e}, {2'h3, 24'hFFFFFF, m}});
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask

	always @(posedge clk) begin
		if ((rvalid && rready) || (bvalid && bready)) begin
			got = (rvalid && rready) ? {rresp, rdata} : {bresp, 32'h0};
			if (rvalid && rready)
				last_rd = rdata;
			if (notes.size() == 0) begin
				`CHK(got, 34'h0)
			end else begin
				cur = notes.pop_front();
				`CHK(got & cur.m, cur.v & cur.m)
			end
		end
	end

	initial begin
		#150000;
		failures++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, press} = 7'h0;
		{awaddr, araddr, wdata, wstrb, kc, kr} = '0;
		rnd = 8'd98;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(col, 5'h1F)
		rd(A_COL, `KPS_RST_COL, 8'hFF, OK);
		rd(A_ROW, `KPS_RST_ROW, 8'hFF, OK);
		rd(A_TIM, `KPS_RST_TIM, 8'hFF, OK);
		rd(A_CTRL, `KPS_RST_CTRL, 8'hF7, OK);
		wr(12'h360, 8'hFF, 4'hF, DEC);
		rd(12'h360, 8'h00, 8'hFF, DEC);
		wr(A_ROW, 8'h00, 4'hF, OK);
		rd(A_ROW, 8'h3F, 8'hFF, OK);
		wr(A_TIM, 8'hA6, 4'hF, OK);
		rd(A_TIM, 8'hA6, 8'hFF, OK);
		wr(A_COL, 8'h00, 4'hE, OK);
		rd(A_COL, 8'h1F, 8'h1F, OK);
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 8'h1E : (i == 1) ? 8'h0F : (i == 2) ? 8'h1F : rnd;
			wr(A_COL, v, 4'hF, OK);
			@(posedge clk);
			#1;
			`CHK(col, v[4:0])
			rd(A_COL, v, 8'h1F, OK);
		end
		// Bypass: firmware drives column zero and samples the rows itself
		wr(A_CTRL, 8'h01, 4'hF, OK);
		wr(A_COL, 8'h1E, 4'hF, OK);
		kc <= 3'd0;
		kr <= 3'd2;
		press <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		rd(A_ROW, 8'h3B, 8'hFF, OK);
		rd(A_CTRL, 8'h03, 8'hF7, OK);
		repeat (3) @(posedge clk);
		#1;
		`CHK(irq, 1'b0)
		rd(A_CTRL, 8'h01, 8'hF7, OK);
		press <= 1'b0;
		wr(A_CTRL, 8'h00, 4'hF, OK);
		press <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(irq, 1'b0)
		rd(A_CTRL, 8'h02, 8'hF7, OK);
		// Raise the flag once more and clear it by writing a one to its bit
		press <= 1'b0;
		repeat (2) @(posedge clk);
		press <= 1'b1;
		repeat (2) @(posedge clk);
		wr(A_CTRL, 8'h02, 4'hF, OK);
		rd(A_CTRL, 8'h00, 8'hF7, OK);
		press <= 1'b0;
		seen = 2'b00;
		for (int i = 0; i < 12; i++) begin
			rd(A_CTRL, 8'h00, 8'hF7, OK);
			#1;
			seen[last_rd[3]] = 1'b1;
		end
		`CHK(seen, 2'b11)
		// Hardware scan across every interval code and the zero debounce field
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			wr(A_TIM, tv[i], 4'hF, OK);
			wr(A_CTRL, 8'h05, 4'hF, OK);
			repeat (2) @(posedge clk);
			#1;
			`CHK(col, 5'h00)
			@(posedge clk);
			kc <= 3'(rnd % 8'd5);
			kr <= 3'(rnd[7:4] % 4'd6);
			press <= 1'b1;
			n = 0;
			while (!irq && n < 8000) begin
				@(posedge clk);
				n++;
			end
			t = dbv[i] + 5 * scv[i];
			`CHK(n >= (t - 6) * MS && n <= (t + 2) * MS, 1'b1)
			rd(A_COL, ~(8'h01 << kc), 8'h1F, OK);
			rd(A_ROW, ~(8'h01 << kr) & 8'h3F, 8'hFF, OK);
			rd(A_CTRL, 8'h07, 8'hF7, OK);
			press <= 1'b0;
			repeat ((dbv[i] + 2) * MS) @(posedge clk);
		end
		conclude();
	end
endmodule // keypad_scan_registers_bench
